// ===== hdl/clk_ctrl_pkg.sv
// Constants, types and helpers shared by the clock control block
package clk_ctrl_pkg;

    // =========================================================
    // Register map (index kept; byte address is four times it)
    localparam logic [7:0] XTAL_IDX = 8'h0b;
    localparam logic [7:0] SEL_IDX = 8'h0c;
    localparam logic [7:0] STAT_IDX = 8'h0d;
    localparam logic [7:0] XTAL_ADDR = XTAL_IDX << 2;
    localparam logic [7:0] SEL_ADDR = SEL_IDX << 2;
    localparam logic [7:0] STAT_ADDR = STAT_IDX << 2;

    // =========================================================
    // Reset values
    localparam logic [7:0] XTAL_RST = 8'h00;
    localparam logic [7:0] SEL_RST = 8'h34;

    // =========================================================
    // Field positions
    localparam int XTAL_EN_BIT = 7;
    localparam int DRIVE_HI = 6;
    localparam int DRIVE_LO = 5;
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 5;
    localparam int FAST_EN_BIT = 4;
    localparam int DIV_BIT = 3;
    localparam int SLOW_EN_BIT = 2;
    localparam int STAT_BUSY_BIT = 3;

    // =========================================================
    // Field encodings
    localparam logic [1:0] DRIVE_LOW = 2'h1;
    localparam logic [1:0] DRIVE_MID = 2'h2;
    localparam logic [1:0] DRIVE_HIGH = 2'h3;
    localparam logic [2:0] MODE_FAST_A = 3'h0;
    localparam logic [2:0] MODE_FAST_B = 3'h1;
    localparam logic [2:0] MODE_FAST_C = 3'h3;
    localparam logic [2:0] MODE_XTAL = 3'h5;
    localparam logic [2:0] MODE_SLOW = 3'h7;
    localparam logic [5:0] DIV_ONE = 6'h01;

    // =========================================================
    // Types
    typedef enum logic [2:0] {
        SRC_DIV2, SRC_DIV4, SRC_DIV8, SRC_DIV16, SRC_DIV32, SRC_DIV64, SRC_SLOW, SRC_XTAL
    } clk_src_t;

    typedef enum logic {SW_RUN, SW_WAIT_NEW} sw_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic xtal_en;
        logic [1:0] xtal_drive;
        logic fast_en;
        logic slow_en;
    } osc_ctl_t;

    typedef struct packed {
        sw_state_t st;
        clk_src_t cur;
        logic clk;
    } sw_reg_t;

    typedef struct packed {
        logic [7:0] xtal_ctl;
        logic [7:0] sel;
        logic [31:0] prdata;
        logic xtal_s1;
        logic xtal_s2;
        logic fast_s1;
        logic fast_s2;
        logic fast_prev;
        logic slow_s1;
        logic slow_s2;
        logic [5:0] div_cnt;
    } ctl_reg_t;

    // =========================================================
    // Clock select value to source
    function automatic clk_src_t decode_sel(input logic [7:0] v);
        clk_src_t s;
        s = SRC_DIV64;
        unique case (v[MODE_HI:MODE_LO])
            MODE_FAST_A: s = v[DIV_BIT] ? SRC_DIV16 : SRC_DIV4;
            MODE_FAST_B: s = v[DIV_BIT] ? SRC_DIV8 : SRC_DIV2;
            MODE_FAST_C: s = v[DIV_BIT] ? SRC_DIV32 : SRC_DIV64;
            MODE_XTAL: s = SRC_XTAL;
            MODE_SLOW: s = SRC_SLOW;
            default: s = SRC_DIV64;
        endcase
        return s;
    endfunction

    // Present level of a source
    function automatic logic src_level(input clk_src_t s, input logic [5:0] cnt,
                                       input logic slow, input logic xtal);
        logic l;
        l = 1'b0;
        unique case (s)
            SRC_SLOW: l = slow;
            SRC_XTAL: l = xtal;
            default: l = cnt[s];
        endcase
        return l;
    endfunction

endpackage

// ===== hdl/clk_glitchless_switch.sv
// Glitch-free switch between clock sources given as sampled levels
`timescale 1ns/1ps
module clk_glitchless_switch (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input clk_ctrl_pkg::clk_src_t req_src_in,
    input wire logic req_level_in,
    input wire logic cur_level_in,
    output clk_ctrl_pkg::clk_src_t cur_src_out,
    output logic clk_out,
    output logic busy_out
);

    clk_ctrl_pkg::sw_reg_t state_r;
    clk_ctrl_pkg::sw_reg_t state_nxt;

    // Leave old source only while low, join new source only while low
    always_comb begin
        state_nxt = state_r;
        unique case (state_r.st)
            clk_ctrl_pkg::SW_RUN: begin
                state_nxt.clk = cur_level_in;
                if (req_src_in != state_r.cur && !cur_level_in) begin
                    state_nxt.st = clk_ctrl_pkg::SW_WAIT_NEW;
                    state_nxt.clk = 1'b0;
                end
            end
            clk_ctrl_pkg::SW_WAIT_NEW: begin
                state_nxt.clk = 1'b0;
                if (!req_level_in) begin
                    state_nxt.cur = req_src_in;
                    state_nxt.st = clk_ctrl_pkg::SW_RUN;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state_r <= '{st: clk_ctrl_pkg::SW_RUN,
                         cur: clk_ctrl_pkg::decode_sel(clk_ctrl_pkg::SEL_RST),
                         clk: 1'b0};
        end else if (ce_in) begin
            state_r <= state_nxt;
        end
    end

    assign cur_src_out = state_r.cur;
    assign clk_out = state_r.clk;
    assign busy_out = (state_r.st == clk_ctrl_pkg::SW_WAIT_NEW) || (req_src_in != state_r.cur);

endmodule

// ===== hdl/crystal_osc_and_sysclk_switch.sv
// Crystal oscillator control and system clock source selector
//
// Contract
// - Bit 7 of the crystal control register powers the crystal oscillator on or off.
// - Bits 6:5 of the crystal control register set drive, 01 low, 10 middle, 11 high.
// - Writing the clock select register changes the system clock at any time, at once; the code waits for the old, then the new source to be low.
// - Select value 0x34 gives fast RC/2, 0xF4 the slow RC and 0xB0 the crystal.
// - Changing between fast RC divider settings, e.g. 0x14, touches no oscillator enable.
// - Crystal, fast RC and slow RC have independent enables: bit 7, select bit 4, bit 2.
// - After reset both the fast RC and the slow RC are enabled.
`timescale 1ns/1ps
module crystal_osc_and_sysclk_switch (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input clk_ctrl_pkg::apb_req_t apb_in,
    output clk_ctrl_pkg::apb_rsp_t apb_out,
    input wire logic crystal_clk_in,
    input wire logic fast_rc_clk_in,
    input wire logic slow_rc_clk_in,
    output clk_ctrl_pkg::osc_ctl_t osc_ctl_out,
    output clk_ctrl_pkg::clk_src_t active_src_out,
    output logic sys_clk_out
);

    // All state and its next copy
    clk_ctrl_pkg::ctl_reg_t state_r;
    clk_ctrl_pkg::ctl_reg_t state_nxt;

    // Source selection and changeover
    clk_ctrl_pkg::clk_src_t req_src;
    clk_ctrl_pkg::clk_src_t cur_src;
    logic req_level;
    logic cur_level;
    logic sw_busy;

    // Bus decode
    logic setup;
    logic access;
    logic mapped;
    logic hit_xtal;
    logic hit_sel;
    logic hit_stat;
    logic wr_xtal;
    logic wr_sel;
    logic rd_load;
    logic [7:0] status_byte;
    logic [31:0] rd_word;

    // Register fields and divider edge
    logic xtal_en;
    logic [1:0] xtal_drive;
    logic fast_en;
    logic slow_en;
    logic fast_rise;

    // =========================================================
    // Helpers

    // Register byte carried in the low lane of a bus word
    function automatic logic [7:0] low_byte(input logic [31:0] w);
        return w[7:0];
    endfunction

    // Bus word read back: register byte low, zeros above
    function automatic logic [31:0] read_word(input logic [7:0] b);
        return {24'h000000, b};
    endfunction

    // Status byte: active source code and pending-switch flag
    function automatic logic [7:0] status_of(input clk_ctrl_pkg::clk_src_t s,
                                             input logic b);
        logic [7:0] v;
        v = '0;
        v[2:0] = s;
        v[clk_ctrl_pkg::STAT_BUSY_BIT] = b;
        return v;
    endfunction

    // =========================================================
    // Bus decode

    // Phase of the transfer on the bus
    assign setup = apb_in.psel && !apb_in.penable;
    assign access = apb_in.psel && apb_in.penable;

    // One hit per register; anything else is unmapped
    assign hit_xtal = (apb_in.paddr == clk_ctrl_pkg::XTAL_ADDR);
    assign hit_sel = (apb_in.paddr == clk_ctrl_pkg::SEL_ADDR);
    assign hit_stat = (apb_in.paddr == clk_ctrl_pkg::STAT_ADDR);
    assign mapped = hit_xtal || hit_sel || hit_stat;

    // Writes land at the end of the access phase; only byte lane 0 counts
    assign wr_xtal = access && apb_in.pwrite && apb_in.pstrb[0] && hit_xtal;
    assign wr_sel = access && apb_in.pwrite && apb_in.pstrb[0] && hit_sel;

    // Read data is captured at the setup edge, so it stands all through access
    assign rd_load = setup && !apb_in.pwrite;

    // Status seen by software while a changeover is pending
    assign status_byte = status_of(cur_src, sw_busy);

    // Read mux over the three registers
    always_comb begin
        rd_word = '0;
        if (hit_xtal) begin
            rd_word = read_word(state_r.xtal_ctl);
        end else if (hit_sel) begin
            rd_word = read_word(state_r.sel);
        end else if (hit_stat) begin
            rd_word = read_word(status_byte);
        end
    end

    // =========================================================
    // Register fields

    // Independent oscillator enables and crystal drive code
    assign xtal_en = state_r.xtal_ctl[clk_ctrl_pkg::XTAL_EN_BIT];
    assign xtal_drive = state_r.xtal_ctl[clk_ctrl_pkg::DRIVE_HI:clk_ctrl_pkg::DRIVE_LO];
    assign fast_en = state_r.sel[clk_ctrl_pkg::FAST_EN_BIT];
    assign slow_en = state_r.sel[clk_ctrl_pkg::SLOW_EN_BIT];

    // =========================================================
    // Next state: registers, synchronisers, fast RC divider

    // Rising edge of the synchronised fast RC level
    assign fast_rise = state_r.fast_s2 && !state_r.fast_prev;

    // Fill the next copy of all state
    always_comb begin
        state_nxt = state_r;
        // Read capture
        if (rd_load) begin
            state_nxt.prdata = rd_word;
        end
        // Crystal control: enable and drive code
        if (wr_xtal) begin
            state_nxt.xtal_ctl = low_byte(apb_in.pwdata);
        end
        // Clock select: source code and RC enables
        if (wr_sel) begin
            state_nxt.sel = low_byte(apb_in.pwdata);
        end
        // Two flops per oscillator pin before anything reads it
        state_nxt.xtal_s1 = crystal_clk_in;
        state_nxt.xtal_s2 = state_r.xtal_s1;
        state_nxt.fast_s1 = fast_rc_clk_in;
        state_nxt.fast_s2 = state_r.fast_s1;
        state_nxt.fast_prev = state_r.fast_s2;
        state_nxt.slow_s1 = slow_rc_clk_in;
        state_nxt.slow_s2 = state_r.slow_s1;
        // Free-running divider keeps every ratio phase-stable
        if (fast_rise) begin
            state_nxt.div_cnt = state_r.div_cnt + clk_ctrl_pkg::DIV_ONE;
        end
    end

    // State register; reset restores the boot values
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state_r <= '{xtal_ctl: clk_ctrl_pkg::XTAL_RST,
                         sel: clk_ctrl_pkg::SEL_RST,
                         prdata: '0,
                         xtal_s1: 1'b0,
                         xtal_s2: 1'b0,
                         fast_s1: 1'b0,
                         fast_s2: 1'b0,
                         fast_prev: 1'b0,
                         slow_s1: 1'b0,
                         slow_s2: 1'b0,
                         div_cnt: '0};
        end else if (ce_in) begin
            state_r <= state_nxt;
        end
    end

    // =========================================================
    // Source decode and levels

    // Source asked for by the select register
    assign req_src = clk_ctrl_pkg::decode_sel(state_r.sel);

    // Sampled level of the asked-for and of the running source
    assign req_level = clk_ctrl_pkg::src_level(req_src, state_r.div_cnt,
                                               state_r.slow_s2, state_r.xtal_s2);
    assign cur_level = clk_ctrl_pkg::src_level(cur_src, state_r.div_cnt,
                                               state_r.slow_s2, state_r.xtal_s2);

    // Glitch-free changeover
    clk_glitchless_switch u_switch (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .req_src_in(req_src),
        .req_level_in(req_level),
        .cur_level_in(cur_level),
        .cur_src_out(cur_src),
        .clk_out(sys_clk_out),
        .busy_out(sw_busy)
    );

    // =========================================================
    // Outputs

    // Oscillator enables and crystal drive straight from the registers
    assign osc_ctl_out.xtal_en = xtal_en;
    assign osc_ctl_out.xtal_drive = xtal_drive;
    assign osc_ctl_out.fast_en = fast_en;
    assign osc_ctl_out.slow_en = slow_en;

    // Source now driving the system clock
    assign active_src_out = cur_src;

    // Bus answer: zero wait states, error on an unmapped address
    assign apb_out.prdata = state_r.prdata;
    assign apb_out.pready = access;
    assign apb_out.pslverr = access && !mapped;

endmodule

// ===== verification/clk_ctrl_assertions.sv
// Port assertions for the clock control block, with their bind
`timescale 1ns/1ps
module clk_ctrl_assertions (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input clk_ctrl_pkg::apb_req_t apb_in,
    input clk_ctrl_pkg::apb_rsp_t apb_out,
    input clk_ctrl_pkg::osc_ctl_t osc_ctl_out,
    input clk_ctrl_pkg::clk_src_t active_src_out,
    input wire logic sys_clk_out
);
    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);
    logic wr;
    logic odd;
    // Accepted write and unmapped address
    assign wr = apb_in.psel & apb_in.penable & apb_in.pwrite & apb_in.pstrb[0] & ce_in;
    assign odd = !(apb_in.paddr inside {clk_ctrl_pkg::XTAL_ADDR, clk_ctrl_pkg::SEL_ADDR,
        clk_ctrl_pkg::STAT_ADDR});
    // =========================================================
    // Bus steps
    sequence acc;
        apb_in.psel && apb_in.penable;
    endsequence
    sequence xwr;
        wr && apb_in.paddr == clk_ctrl_pkg::XTAL_ADDR;
    endsequence
    sequence swr;
        wr && apb_in.paddr == clk_ctrl_pkg::SEL_ADDR;
    endsequence
    // =========================================================
    // Checks
    xtal_enable_a: assert property (
        xwr |=> osc_ctl_out.xtal_en == $past(apb_in.pwdata[7])) else $error("bad xtal enable");
    drive_code_a: assert property (
        xwr |=> osc_ctl_out.xtal_drive == $past(apb_in.pwdata[6:5])) else $error("bad drive");
    fast_enable_a: assert property (
        swr |=> osc_ctl_out.fast_en == $past(apb_in.pwdata[4])) else $error("bad fast enable");
    slow_enable_a: assert property (
        swr |=> osc_ctl_out.slow_en == $past(apb_in.pwdata[2])) else $error("bad slow enable");
    enables_hold_a: assert property (
        !wr |=> $stable(osc_ctl_out)) else $error("enable moved without write");
    ready_now_a: assert property (
        acc |-> apb_out.pready) else $error("no ready in access");
    unmapped_err_a: assert property (
        acc ##0 odd |-> apb_out.pslverr) else $error("no error on unmapped");
    switch_quiet_a: assert property (
        $changed(active_src_out) |-> !$past(sys_clk_out)) else $error("switch while high");
    slow_select_a: assert property (
        swr ##0 apb_in.pwdata[7:0] == 8'hf4 |-> ##[1:300] active_src_out == clk_ctrl_pkg::SRC_SLOW)
        else $error("slow not reached");
endmodule
bind crystal_osc_and_sysclk_switch clk_ctrl_assertions i_chk (.mclk_in(mclk_in),
    .rst_in(rst_in), .ce_in(ce_in), .apb_in(apb_in), .apb_out(apb_out),
    .osc_ctl_out(osc_ctl_out), .active_src_out(active_src_out), .sys_clk_out(sys_clk_out));

// ===== verification/testbench.sv
// Self-checking testbench for the clock control block
`timescale 1ns/1ps
module testbench;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic ce_in = 1'b1;
    logic crystal_clk_in = 1'b0;
    logic fast_rc_clk_in = 1'b0;
    logic slow_rc_clk_in = 1'b0;
    logic [2:0] osc_cnt = 3'h0;
    clk_ctrl_pkg::apb_req_t apb_in = '0;
    clk_ctrl_pkg::apb_rsp_t apb_out;
    clk_ctrl_pkg::osc_ctl_t osc_ctl_out;
    clk_ctrl_pkg::clk_src_t active_src_out;
    logic sys_clk_out;
    int err_total = 0;
    int compares = 0;
    crystal_osc_and_sysclk_switch i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in),
        .apb_in(apb_in), .apb_out(apb_out), .crystal_clk_in(crystal_clk_in),
        .fast_rc_clk_in(fast_rc_clk_in), .slow_rc_clk_in(slow_rc_clk_in),
        .osc_ctl_out(osc_ctl_out), .active_src_out(active_src_out), .sys_clk_out(sys_clk_out));
    // =========================================================
    // Clock and oscillator levels
    always #12.5 mclk_in = ~mclk_in;
    always @(posedge mclk_in) begin
        osc_cnt <= osc_cnt + 3'h1;
        fast_rc_clk_in <= ~fast_rc_clk_in;
        crystal_clk_in <= osc_cnt[1];
        slow_rc_clk_in <= osc_cnt[2];
    end
    // =========================================================
    // Shared tasks
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic tmo();
        err_total++;
        $display("ERROR %0t wait ran out", $time);
        conclude();
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t %s seen %h exp %h", $time, m, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        @(posedge mclk_in);
        apb_in <= '{1'b1, 1'b0, w, a, d, 4'hf};
        @(posedge mclk_in);
        apb_in.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk_in);
            n++;
        end while (apb_out.pready !== 1'b1 && n < 50);
        if (n >= 50) tmo();
        q = apb_out.prdata;
        e = apb_out.pslverr;
        apb_in <= '0;
        @(negedge mclk_in);
    endtask
    // =========================================================
    // Scenarios
    task automatic t_reset();
        logic [31:0] q;
        logic e;
        bus(1'b0, clk_ctrl_pkg::XTAL_ADDR, 32'h0, q, e);
        chk(q, 32'h00, "xtal reset");
        bus(1'b0, clk_ctrl_pkg::SEL_ADDR, 32'h0, q, e);
        chk(q, 32'h34, "sel reset");
        chk(osc_ctl_out, 5'h03, "osc reset");
        chk(active_src_out, 3'h0, "src reset");
        $display("reset test done");
    endtask
    task automatic t_xtal();
        logic [31:0] q;
        logic [31:0] v;
        logic e;
        for (int i = 1; i < 4; i++) begin
            v = {24'h000000, 1'b1, i[1:0], 5'h00};
            bus(1'b1, clk_ctrl_pkg::XTAL_ADDR, v, q, e);
            chk(osc_ctl_out, {1'b1, i[1:0], 2'b11}, "xtal ctl");
            bus(1'b0, clk_ctrl_pkg::XTAL_ADDR, 32'h0, q, e);
            chk(q, v, "xtal read");
        end
        bus(1'b1, clk_ctrl_pkg::XTAL_ADDR, 32'h0, q, e);
        chk(osc_ctl_out.xtal_en, 1'b0, "xtal off");
        $display("crystal test done");
    endtask
    task automatic t_sel();
        logic [7:0] sv [14] = '{8'h14, 8'h3c, 8'h1c, 8'h7c, 8'h74, 8'hf4, 8'h34, 8'hb4,
            8'ha4, 8'hb4, 8'hb0, 8'hb4, 8'h34, 8'h30};
        logic [2:0] se [14] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0, 3'h7, 3'h7, 3'h7,
            3'h7, 3'h7, 3'h0, 3'h0};
        // Rising system clock edges in 128 cycles for each source
        int rs [14] = '{32'h10, 32'h8, 32'h4, 32'h2, 32'h1, 32'h10, 32'h20, 32'h20, 32'h20,
            32'h20, 32'h20, 32'h20, 32'h20, 32'h20};
        logic [31:0] q;
        logic e;
        int n;
        int r;
        logic p;
        // Crystal running well before it is chosen
        bus(1'b1, clk_ctrl_pkg::XTAL_ADDR, 32'he0, q, e);
        for (int i = 0; i < 14; i++) begin
            bus(1'b1, clk_ctrl_pkg::SEL_ADDR, {24'h0, sv[i]}, q, e);
            n = 0;
            while (active_src_out !== se[i] && n < 300) begin
                @(negedge mclk_in);
                n++;
            end
            if (n >= 300) tmo();
            chk(active_src_out, se[i], "source");
            chk(osc_ctl_out.fast_en, sv[i][4], "fast en");
            chk(osc_ctl_out.slow_en, sv[i][2], "slow en");
            bus(1'b0, clk_ctrl_pkg::STAT_ADDR, 32'h0, q, e);
            chk(q[3:0], {1'b0, se[i]}, "status");
            // System clock must now follow the chosen source
            r = 0;
            p = sys_clk_out;
            repeat (128) begin
                @(negedge mclk_in);
                if (sys_clk_out === 1'b1 && p === 1'b0) r++;
                p = sys_clk_out;
            end
            chk(r, rs[i], "clock rises");
        end
        $display("select test done");
    endtask
    task automatic t_err();
        logic [31:0] q;
        logic e;
        bus(1'b1, 8'h00, 32'hff, q, e);
        chk(e, 1'b1, "write error");
        bus(1'b0, 8'h00, 32'h0, q, e);
        chk(e, 1'b1, "read error");
        chk(q, 32'h0, "read zero");
        bus(1'b0, clk_ctrl_pkg::SEL_ADDR, 32'h0, q, e);
        chk(q, 32'h30, "sel kept");
        $display("error test done");
    endtask
    // =========================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge mclk_in);
        rst_in <= 1'b0;
        t_reset();
        t_xtal();
        t_sel();
        t_err();
        conclude();
    end
endmodule
